// [core/upsc_pkg.sv]
package upsc_pkg;

    // Clock rate in kHz; timing counts are derived from it.
    localparam int unsigned CLK_KHZ          = 10000;

    // Documented times, each in its own unit.
    localparam int unsigned OC_DEGLITCH_MS   = 5;
    localparam int unsigned HICCUP_ON_MS     = 5;
    localparam int unsigned HICCUP_OFF_S     = 2;
    localparam int unsigned LOWV_FILTER_US   = 50;
    localparam int unsigned THERM_RECOVER_S  = 16;
    localparam int unsigned CC_DISCH_US      = 20;
    localparam int unsigned CC_PROBE_US      = 20;

    // Cycle counts derived from the times above.
    localparam int unsigned OC_DEGLITCH_CYC  = OC_DEGLITCH_MS * CLK_KHZ;
    localparam int unsigned HICCUP_ON_CYC    = HICCUP_ON_MS * CLK_KHZ;
    localparam int unsigned HICCUP_OFF_CYC   = HICCUP_OFF_S * 1000 * CLK_KHZ;
    localparam int unsigned LOWV_FILTER_CYC  =
        (LOWV_FILTER_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned THERM_RECOVER_CYC =
        THERM_RECOVER_S * 1000 * CLK_KHZ;
    localparam int unsigned CC_DISCH_CYC     =
        (CC_DISCH_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned CC_PROBE_CYC     =
        (CC_PROBE_US * CLK_KHZ + 999) / 1000;

    // Termination seen on one CC pin, from the comparator pair.
    typedef enum logic [1:0] {
        CC_OPEN = 2'b00,
        CC_RD   = 2'b01,
        CC_RA   = 2'b10
    } upsc_cc_t;

    // Attach state machine.
    typedef enum logic [2:0] {
        ST_PROBE_DIS = 3'b000,
        ST_PROBE_SRC = 3'b001,
        ST_UNATTACH  = 3'b010,
        ST_ATTACHED  = 3'b011,
        ST_AUDIO     = 3'b100,
        ST_DEBUG     = 3'b101,
        ST_TYPEA     = 3'b110
    } upsc_state_t;

endpackage : upsc_pkg

// [core/upsc_sync.sv]
`timescale 1ns/1ps
module upsc_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_n,
    // Data
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // Only the second stage is seen outside.
    always_comb
    begin
        meta_d = din;
        sync_d = meta_q;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign dout = sync_q;

endmodule : upsc_sync

// [core/upsc_timer.sv]
`timescale 1ns/1ps
module upsc_timer #(
    parameter int unsigned WIDTH = 32
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_n,
    // Control
    input  wire logic             run,
    input  wire logic [WIDTH-1:0] limit,
    output logic                  done
);

    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] cnt_d;

    // Counts while run is high and saturates; clears when run drops.
    always_comb
    begin
        if (!run)
            cnt_d = '0;
        else if (cnt_q < limit)
            cnt_d = cnt_q + 1'b1;
        else
            cnt_d = cnt_q;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
    end

    assign done = run && (cnt_q >= limit);

endmodule : upsc_timer

// [core/usb_port_source_control.sv]
// Summary of operation
// R1: Fast discharge on while CC released or switch disabled by lockout or enables.
// R2: Fast discharge stops once port voltage is below 50mV.
// R3: Switch follows port enable; low or floating enable switches off with discharge.
// R4: Fault output stays released in shutdown, start-up and normal running.
// R5: Fault low on over-current or hot; held until cleared and voltage back.
// R6: Over-current must last 5ms, then hiccup starts and fault goes low.
// R7: Over-temperature drives fault low with no deglitch.
// R8: Attach detection is a state machine: probe, unattached, attached, audio, debug and Type-A.
// R9: Pull-ups on both CC pins; sink seen as voltage below open level.
// R10: Rd told from Ra per pin; VCONN only on the Ra pin.
// R11: Ra/Ra is audio, Rd/Rd is debug; VBUS stays off for both.
// R12: VBUS starts off; enabled with VCONN once a sink is found.
// R13: Advertise 3A by default, 1.5A pull-up when the die is hot.
// R14: Loss of Rd removes VBUS and VCONN and returns to detection.
// R15: Start-up probe discharges CC1, sources test current, checks window.
// R16: CC1 inside window latches Type-A mode until re-enabled.
// R17: Type-A mode: attached, no detach, VBUS on, Type-A current limit.
// R18: Board sets Type-A by resistor only; Type-C boards fit a CC1 capacitor.
// R19: Hiccup cycles switch 5ms on, 2s off while overload persists.
// R20: Port below 3.5V for 50us after soft start enters hiccup at once.
// R21: 3A restored only after 16s below the recovery threshold.
// R22: All comparator, fault and enable inputs are synchronised first.
// R23: Lockout or chip enable low resets state machine, timers and latch.
`timescale 1ns/1ps
module usb_port_source_control #(
    parameter int unsigned OC_DEGLITCH_CYC   = upsc_pkg::OC_DEGLITCH_CYC,
    parameter int unsigned HICCUP_ON_CYC     = upsc_pkg::HICCUP_ON_CYC,
    parameter int unsigned HICCUP_OFF_CYC    = upsc_pkg::HICCUP_OFF_CYC,
    parameter int unsigned THERM_RECOVER_CYC = upsc_pkg::THERM_RECOVER_CYC
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // Enables and supply
    input  wire logic chipEnable,
    input  wire logic input_undervoltage_lockout,
    input  wire logic portEnable,
    // Analog comparators on the port output
    input  wire logic overCurrent,
    input  wire logic overTemp,
    input  wire logic thermHigh,
    input  wire logic thermRecovered,
    input  wire logic vbusBelow50mv,
    input  wire logic vbusBelow3v5,
    input  wire logic softStartDone,
    // CC comparators: below open level and below the Ra level, per pin
    input  wire logic cc1BelowOpen,
    input  wire logic cc1BelowRa,
    input  wire logic cc2BelowOpen,
    input  wire logic cc2BelowRa,
    input  wire logic cc1InWindow,
    // Power path controls
    output logic      portSwitchOn,
    output logic      fastDischarge,
    output logic      vconnCc1,
    output logic      vconnCc2,
    output logic      rpAdvertise1a5,
    output logic      typeALimit,
    output logic      cc1ProbeDischarge,
    output logic      cc1ProbeSource,
    output logic      hiccupActive,
    // Fault pin, open drain: enable low means driven
    output logic      port_fault_flag_n_o,
    output logic      port_fault_flag_n_oe_n
);

    localparam int unsigned TW = 32;

    // Synchronised inputs.
    logic [14:0] rawIn;
    logic [14:0] syn;
    logic        sEn;
    logic        sUvlo;
    logic        sPortEn;
    logic        sOc;
    logic        sOt;
    logic        sHot;
    logic        sCool;
    logic        sBelow50;
    logic        sBelow3v5;
    logic        sSsDone;
    logic        sC1o;
    logic        sC1a;
    logic        sC2o;
    logic        sC2a;
    logic        sWin;

    assign rawIn = {chipEnable, input_undervoltage_lockout, portEnable,
                    overCurrent, overTemp, thermHigh, thermRecovered,
                    vbusBelow50mv, vbusBelow3v5, softStartDone,
                    cc1BelowOpen, cc1BelowRa, cc2BelowOpen, cc2BelowRa,
                    cc1InWindow};

    upsc_sync #(.WIDTH(15)) u_sync ( // R22
        .mclk  (mclk),
        .rst_n (rst_n),
        .din   (rawIn),
        .dout  (syn)
    );

    assign {sEn, sUvlo, sPortEn, sOc, sOt, sHot, sCool, sBelow50,
            sBelow3v5, sSsDone, sC1o, sC1a, sC2o, sC2a, sWin} = syn;

    // Chip-level shutdown clears all state below except fast discharge, which stays on while voltage remains.
    logic chipOff;
    assign chipOff = !sEn || sUvlo; // R23

    // Per-pin termination decode; Ra pulls further than Rd.
    upsc_pkg::upsc_cc_t cc1Term;
    upsc_pkg::upsc_cc_t cc2Term;
    always_comb
    begin
        cc1Term = !sC1o ? upsc_pkg::CC_OPEN :
                  (sC1a ? upsc_pkg::CC_RA : upsc_pkg::CC_RD); // R9 R10
        cc2Term = !sC2o ? upsc_pkg::CC_OPEN :
                  (sC2a ? upsc_pkg::CC_RA : upsc_pkg::CC_RD); // R9 R10
    end

    // Timers.
    logic ocRun, ocDone, lowvRun, lowvDone, probeRun, probeDone;
    logic hicRun, hicDone, coolRun, coolDone;
    logic [TW-1:0] probeLimit;
    logic [TW-1:0] hicLimit;

    upsc_timer #(.WIDTH(TW)) u_octmr (
        .mclk  (mclk),
        .rst_n (rst_n),
        .run   (ocRun),
        .limit (TW'(OC_DEGLITCH_CYC)),
        .done  (ocDone)
    );

    upsc_timer #(.WIDTH(TW)) u_lowvtmr (
        .mclk  (mclk),
        .rst_n (rst_n),
        .run   (lowvRun),
        .limit (TW'(upsc_pkg::LOWV_FILTER_CYC)),
        .done  (lowvDone)
    );

    upsc_timer #(.WIDTH(TW)) u_hictmr (
        .mclk  (mclk),
        .rst_n (rst_n),
        .run   (hicRun),
        .limit (hicLimit),
        .done  (hicDone)
    );

    upsc_timer #(.WIDTH(TW)) u_cooltmr (
        .mclk  (mclk),
        .rst_n (rst_n),
        .run   (coolRun),
        .limit (TW'(THERM_RECOVER_CYC)),
        .done  (coolDone)
    );

    upsc_timer #(.WIDTH(TW)) u_probetmr (
        .mclk  (mclk),
        .rst_n (rst_n),
        .run   (probeRun),
        .limit (probeLimit),
        .done  (probeDone)
    );

    // State.
    upsc_pkg::upsc_state_t st_q, st_d;
    logic hic_q, hic_d;          // In hiccup.
    logic hicOff_q, hicOff_d;    // Hiccup phase: off.
    logic flt_q, flt_d;          // Fault asserted.
    logic hot_q, hot_d;          // 1.5A advertisement.
    logic disch_q, disch_d;
    logic sw_q, sw_d;
    logic v1_q, v1_d, v2_q, v2_d;
    logic pd_q, pd_d, ps_q, ps_d;
    logic ta_q, ta_d;
    logic cyc_q, cyc_d;          // Restart of the probe timer.
    logic hicGap_q;              // Restart of the hiccup timer.

    logic attached;
    logic portUp;
    logic enOk;

    assign enOk     = !chipOff && sPortEn; // R3
    assign attached = (st_q == upsc_pkg::ST_ATTACHED) ||
                      (st_q == upsc_pkg::ST_TYPEA);
    assign portUp   = enOk && attached;

    always_comb
    begin
        st_d  = st_q;
        cyc_d = 1'b0;
        case (st_q) // R8
            upsc_pkg::ST_PROBE_DIS:
            begin
                if (probeDone) // R15
                begin
                    st_d  = upsc_pkg::ST_PROBE_SRC;
                    cyc_d = 1'b1;
                end
            end
            upsc_pkg::ST_PROBE_SRC:
            begin
                if (probeDone)
                    st_d = sWin ? upsc_pkg::ST_TYPEA // R16
                                : upsc_pkg::ST_UNATTACH;
            end
            upsc_pkg::ST_UNATTACH:
            begin
                if (cc1Term == upsc_pkg::CC_RA && cc2Term == upsc_pkg::CC_RA)
                    st_d = upsc_pkg::ST_AUDIO; // R11
                else if (cc1Term == upsc_pkg::CC_RD &&
                         cc2Term == upsc_pkg::CC_RD)
                    st_d = upsc_pkg::ST_DEBUG; // R11
                else if (cc1Term == upsc_pkg::CC_RD ||
                         cc2Term == upsc_pkg::CC_RD)
                    st_d = upsc_pkg::ST_ATTACHED; // R12
            end
            upsc_pkg::ST_ATTACHED, upsc_pkg::ST_DEBUG:
            begin
                if (cc1Term != upsc_pkg::CC_RD && cc2Term != upsc_pkg::CC_RD)
                    st_d = upsc_pkg::ST_UNATTACH; // R14
            end
            upsc_pkg::ST_AUDIO:
            begin
                if (cc1Term != upsc_pkg::CC_RA || cc2Term != upsc_pkg::CC_RA)
                    st_d = upsc_pkg::ST_UNATTACH;
            end
            upsc_pkg::ST_TYPEA:
                st_d = upsc_pkg::ST_TYPEA; // R17
            default:
                st_d = upsc_pkg::ST_PROBE_DIS;
        endcase
        if (chipOff)
            st_d = upsc_pkg::ST_PROBE_DIS; // R23
    end

    assign probeRun   = !chipOff && !cyc_q &&
                        (st_q == upsc_pkg::ST_PROBE_DIS ||
                         st_q == upsc_pkg::ST_PROBE_SRC);
    assign probeLimit = (st_q == upsc_pkg::ST_PROBE_DIS)
                        ? TW'(upsc_pkg::CC_DISCH_CYC)
                        : TW'(upsc_pkg::CC_PROBE_CYC);

    // Over-current deglitch and the low-voltage shortcut run while on.
    assign ocRun   = sw_q && sOc && !hic_q; // R6
    assign lowvRun = sw_q && sSsDone && sBelow3v5 && !hic_q; // R20
    assign hicRun  = hic_q && !hicGap_q;
    assign hicLimit = hicOff_q ? TW'(HICCUP_OFF_CYC) : TW'(HICCUP_ON_CYC);
    assign coolRun = hot_q && sCool && !sHot;

    // Hiccup: one timer serves both phases, cleared between them.
    // An on phase ends with a fresh check of the overload.
    always_comb
    begin
        hic_d    = hic_q;
        hicOff_d = hicOff_q;
        if (!hic_q)
        begin
            if (ocDone || lowvDone) // R6 R20
            begin
                hic_d    = 1'b1;
                hicOff_d = 1'b1;
            end
        end
        else if (hicDone) // R19
        begin
            if (hicOff_q)
                hicOff_d = 1'b0;
            else if (sOc || sBelow3v5)
                hicOff_d = 1'b1;
            else
                hic_d = 1'b0;
        end
        if (chipOff || !sPortEn)
        begin
            hic_d    = 1'b0; // R23
            hicOff_d = 1'b0;
        end
    end

    always_comb
    begin
        // Fault: set wins over the clear condition in the same cycle.
        flt_d = flt_q;
        if (!sOt && !sOc && !sBelow3v5 && !hic_q)
            flt_d = 1'b0; // R5
        if (sOt || ocDone || lowvDone)
            flt_d = 1'b1; // R5 R6 R7
        if (chipOff || !sPortEn)
            flt_d = 1'b0; // R4

        hot_d = hot_q;
        if (coolDone)
            hot_d = 1'b0; // R21
        if (sHot)
            hot_d = 1'b1; // R13
        if (chipOff)
            hot_d = 1'b0;

        sw_d = portUp && !(hic_q && hicOff_q) && !sOt; // R3 R12 R19
        // Discharge only while the switch is off and voltage remains.
        disch_d = !sw_d && !sBelow50; // R1 R2
        if (st_d == upsc_pkg::ST_ATTACHED && enOk)
        begin
            v1_d = (cc1Term == upsc_pkg::CC_RA); // R10
            v2_d = (cc2Term == upsc_pkg::CC_RA); // R10
        end
        else
        begin
            v1_d = 1'b0; // R14
            v2_d = 1'b0;
        end
        pd_d = !chipOff && st_d == upsc_pkg::ST_PROBE_DIS; // R15
        ps_d = !chipOff && st_d == upsc_pkg::ST_PROBE_SRC; // R15
        ta_d = st_d == upsc_pkg::ST_TYPEA; // R17
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            st_q     <= upsc_pkg::ST_PROBE_DIS;
            hic_q    <= 1'b0;
            hicOff_q <= 1'b0;
            flt_q    <= 1'b0;
            hot_q    <= 1'b0;
            disch_q  <= 1'b0;
            sw_q     <= 1'b0;
            v1_q     <= 1'b0;
            v2_q     <= 1'b0;
            pd_q     <= 1'b0;
            ps_q     <= 1'b0;
            ta_q     <= 1'b0;
            cyc_q    <= 1'b0;
        end
        else
        begin
            st_q     <= st_d;
            hic_q    <= hic_d;
            hicOff_q <= hicOff_d;
            flt_q    <= flt_d;
            hot_q    <= hot_d;
            disch_q  <= disch_d;
            sw_q     <= sw_d;
            v1_q     <= v1_d;
            v2_q     <= v2_d;
            pd_q     <= pd_d;
            ps_q     <= ps_d;
            ta_q     <= ta_d;
            cyc_q    <= cyc_d;
        end
    end

    logic hicOut_q;
    logic fltRel_q;
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            hicOut_q <= 1'b0;
            hicGap_q <= 1'b0;
            fltRel_q <= 1'b1;
        end
        else
        begin
            hicOut_q <= hic_d;
            hicGap_q <= hicDone;
            fltRel_q <= !flt_d;
        end
    end

    assign portSwitchOn           = sw_q;
    assign fastDischarge          = disch_q;
    assign vconnCc1               = v1_q;
    assign vconnCc2               = v2_q;
    assign rpAdvertise1a5         = hot_q;
    assign typeALimit             = ta_q;
    assign cc1ProbeDischarge      = pd_q;
    assign cc1ProbeSource         = ps_q;
    assign hiccupActive           = hicOut_q;
    assign port_fault_flag_n_o    = 1'b0;
    assign port_fault_flag_n_oe_n = fltRel_q; // R4 R5

endmodule : usb_port_source_control

// [sim/upsc_props.sv]
`timescale 1ns/1ps
module upsc_props (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Block inputs
    input wire logic chipEnable,
    input wire logic input_undervoltage_lockout,
    input wire logic portEnable,
    input wire logic overTemp,
    input wire logic thermHigh,
    input wire logic vbusBelow50mv,
    input wire logic cc1BelowOpen,
    input wire logic cc1BelowRa,
    input wire logic cc2BelowOpen,
    input wire logic cc2BelowRa,
    // Block outputs
    input wire logic portSwitchOn,
    input wire logic fastDischarge,
    input wire logic vconnCc1,
    input wire logic vconnCc2,
    input wire logic rpAdvertise1a5,
    input wire logic typeALimit,
    input wire logic cc1ProbeDischarge,
    input wire logic cc1ProbeSource,
    input wire logic hiccupActive,
    input wire logic port_fault_flag_n_oe_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    logic run;
    logic acc;
    logic idle;
    assign run  = chipEnable && !input_undervoltage_lockout;
    // Both pins terminated alike is an accessory, never a sink.
    assign acc  = cc1BelowOpen && cc2BelowOpen && (cc1BelowRa == cc2BelowRa);
    assign idle = !cc1ProbeDischarge && !cc1ProbeSource;

    sequence s_hot;
        thermHigh [*5];
    endsequence
    sequence s_enabled;
        run [*4];
    endsequence

    property p_ot_fault;
        (overTemp && portEnable && run && idle) [*6]
            |-> !port_fault_flag_n_oe_n;
    endproperty
    property p_fault_off;
        (!portEnable) [*6] |-> port_fault_flag_n_oe_n;
    endproperty
    property p_en_off;
        (!portEnable) [*5] |-> !portSwitchOn;
    endproperty
    property p_lockout;
        (!run) [*5] |-> !portSwitchOn && !typeALimit && !vconnCc1 && !vconnCc2;
    endproperty
    property p_disch_on;
        (!portSwitchOn && !vbusBelow50mv) [*5] |-> fastDischarge;
    endproperty
    property p_disch_off;
        vbusBelow50mv [*5] |-> !fastDischarge;
    endproperty
    property p_vconn;
        vconnCc1 |-> !vconnCc2;
    endproperty
    property p_accessory;
        (acc && !typeALimit) [*8] |-> !portSwitchOn;
    endproperty
    property p_unplugged;
        (!cc1BelowOpen && !cc2BelowOpen && !typeALimit) [*6] |-> !portSwitchOn;
    endproperty
    property p_hot;
        s_hot |-> rpAdvertise1a5;
    endproperty
    property p_typea_hold;
        s_enabled ##0 typeALimit |=> typeALimit;
    endproperty
    property p_typea_vbus;
        (typeALimit && portEnable && !hiccupActive && !overTemp) [*5]
            |-> portSwitchOn;
    endproperty
    property p_probe;
        $rose(cc1ProbeSource)
            |-> $past(cc1ProbeDischarge) && !cc1ProbeDischarge;
    endproperty

    a_ot_fault: assert property (p_ot_fault) else $error("no fault");
    a_fault_off: assert property (p_fault_off) else $error("fault");
    a_en_off: assert property (p_en_off) else $error("switch on");
    a_lockout: assert property (p_lockout) else $error("lockout");
    a_disch_on: assert property (p_disch_on) else $error("no disch");
    a_disch_off: assert property (p_disch_off) else $error("disch");
    a_vconn: assert property (p_vconn) else $error("vconn both");
    a_accessory: assert property (p_accessory) else $error("acc");
    a_unplugged: assert property (p_unplugged) else $error("vbus");
    a_hot: assert property (p_hot) else $error("no 1.5A");
    a_typea_hold: assert property (p_typea_hold) else $error("A");
    a_typea_vbus: assert property (p_typea_vbus) else $error("A vbus");
    a_probe: assert property (p_probe) else $error("probe order");
endmodule : upsc_props

bind usb_port_source_control upsc_props i_props (
    .mclk, .rst_n, .chipEnable, .input_undervoltage_lockout, .portEnable,
    .overTemp, .thermHigh, .vbusBelow50mv, .cc1BelowOpen, .cc1BelowRa,
    .cc2BelowOpen, .cc2BelowRa, .portSwitchOn, .fastDischarge, .vconnCc1,
    .vconnCc2, .rpAdvertise1a5, .typeALimit, .cc1ProbeDischarge,
    .cc1ProbeSource, .hiccupActive, .port_fault_flag_n_oe_n
);

// [sim/upsc_sink_model.sv]
`timescale 1ns/1ps
module upsc_sink_model (
    // Clock
    input  wire logic       mclk,
    // Scenario controls
    input  wire logic [1:0] term1,
    input  wire logic [1:0] term2,
    input  wire logic       legacyRes,
    input  wire logic       shortOut,
    // Port power
    input  wire logic       portSwitchOn,
    input  wire logic       fastDischarge,
    // Comparators
    output logic            cc1BelowOpen,
    output logic            cc1BelowRa,
    output logic            cc2BelowOpen,
    output logic            cc2BelowRa,
    output logic            cc1InWindow,
    output logic            vbusBelow50mv,
    output logic            vbusBelow3v5
);
    logic [3:0] level = 4'h0;
    assign cc1BelowOpen = term1 != upsc_pkg::CC_OPEN;
    assign cc1BelowRa   = term1 == upsc_pkg::CC_RA;
    assign cc2BelowOpen = term2 != upsc_pkg::CC_OPEN;
    assign cc2BelowRa   = term2 == upsc_pkg::CC_RA;
    // A Type-C board carries a capacitor, so only a bare resistor settles.
    assign cc1InWindow  = legacyRes;
    assign vbusBelow50mv = level == 4'h0;
    assign vbusBelow3v5  = level < 4'ha;
    // Slow ramps let the bench see discharge before the port is empty.
    always @(posedge mclk)
    begin
        if (shortOut)
            level <= 4'h0;
        else if (portSwitchOn && level != 4'hf)
            level <= level + 4'h1;
        else if (fastDischarge && level != 4'h0)
            level <= level - 4'h1;
    end
endmodule : upsc_sink_model

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic [1:0] t1;
        logic [1:0] t2;
        logic       sw;
        logic       v1;
        logic       v2;
    } upsc_row_t;
    // Terminations: 0 open, 1 Rd, 2 Ra.
    upsc_row_t rows [8] = '{'{2'h1, 2'h0, 1'h1, 1'h0, 1'h0},
        '{2'h0, 2'h1, 1'h1, 1'h0, 1'h0}, '{2'h1, 2'h2, 1'h1, 1'h0, 1'h1},
        '{2'h2, 2'h1, 1'h1, 1'h1, 1'h0}, '{2'h2, 2'h2, 1'h0, 1'h0, 1'h0},
        '{2'h1, 2'h1, 1'h0, 1'h0, 1'h0}, '{2'h2, 2'h0, 1'h0, 1'h0, 1'h0},
        '{2'h0, 2'h0, 1'h0, 1'h0, 1'h0}};
    logic mclk, rst_n, chipEnable, input_undervoltage_lockout, portEnable;
    logic overCurrent, overTemp, thermHigh, thermRecovered, softStartDone;
    logic legacyRes, shortOut, cc1InWindow, vbusBelow50mv, vbusBelow3v5;
    logic [1:0] term1, term2;
    logic cc1BelowOpen, cc1BelowRa, cc2BelowOpen, cc2BelowRa;
    logic portSwitchOn, fastDischarge, vconnCc1, vconnCc2, rpAdvertise1a5;
    logic typeALimit, cc1ProbeDischarge, cc1ProbeSource, hiccupActive;
    logic port_fault_flag_n_o, port_fault_flag_n_oe_n;
    int numErrors = 0;
    int nTests = 0;
    int cycles = 0;
    int k;

    usb_port_source_control #(.OC_DEGLITCH_CYC(20), .HICCUP_ON_CYC(20),
        .HICCUP_OFF_CYC(50), .THERM_RECOVER_CYC(50)) i_dut (.mclk, .rst_n,
        .chipEnable, .input_undervoltage_lockout, .portEnable, .overCurrent,
        .overTemp, .thermHigh, .thermRecovered, .vbusBelow50mv, .vbusBelow3v5,
        .softStartDone, .cc1BelowOpen, .cc1BelowRa, .cc2BelowOpen,
        .cc2BelowRa, .cc1InWindow, .portSwitchOn, .fastDischarge, .vconnCc1,
        .vconnCc2, .rpAdvertise1a5, .typeALimit, .cc1ProbeDischarge,
        .cc1ProbeSource, .hiccupActive, .port_fault_flag_n_o,
        .port_fault_flag_n_oe_n);
    upsc_sink_model i_sink (.mclk, .term1, .term2, .legacyRes, .shortOut,
        .portSwitchOn, .fastDischarge, .cc1BelowOpen, .cc1BelowRa,
        .cc2BelowOpen, .cc2BelowRa, .cc1InWindow, .vbusBelow50mv,
        .vbusBelow3v5);

    initial
    begin
        mclk = 1'h0;
        forever #50 mclk = ~mclk;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc

    task automatic check(input logic seen, input logic exp, input string m);
        nTests++;
        if (seen !== exp)
        begin
            numErrors++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : check

    task automatic end_of_test;
        $display("Checks %0d, errors %0d", nTests, numErrors);
        if (numErrors == 0 && nTests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test

    // A hang anywhere below lands here instead of running on.
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            numErrors++;
            end_of_test();
        end
    end

    initial
    begin
        {rst_n, input_undervoltage_lockout, overCurrent, overTemp} = 4'h0;
        {thermHigh, thermRecovered, softStartDone, legacyRes} = 4'h0;
        {shortOut, term1, term2} = 5'h0;
        {chipEnable, portEnable} = 2'h3;
        cyc(10);
        check(port_fault_flag_n_oe_n, 1'h1, "fault idle");
        check(portSwitchOn, 1'h0, "vbus idle");
        check(port_fault_flag_n_o, 1'h0, "fault data");
        rst_n = 1'h1;
        for (k = 0; k < 20 && cc1ProbeDischarge !== 1'h1; k++) cyc(1);
        for (k = 0; k < 400 && cc1ProbeDischarge === 1'h1; k++) cyc(1);
        check(k == upsc_pkg::CC_DISCH_CYC, 1'h1, "probe length");
        cyc(2);
        check(cc1ProbeSource, 1'h1, "probe source");
        cyc(210);
        check(typeALimit, 1'h0, "no latch");
        foreach (rows[i])
        begin
            term1 = rows[i].t1;
            term2 = rows[i].t2;
            cyc(12);
            check(portSwitchOn, rows[i].sw, "vbus");
            check(vconnCc1, rows[i].v1, "vconn1");
            check(vconnCc2, rows[i].v2, "vconn2");
            term1 = 2'h0;
            term2 = 2'h0;
            cyc(12);
            check(portSwitchOn, 1'h0, "detach");
        end
        term1 = 2'h1;
        cyc(20);
        thermHigh = 1'h1;
        cyc(6);
        check(rpAdvertise1a5, 1'h1, "hot");
        thermHigh = 1'h0;
        thermRecovered = 1'h1;
        cyc(30);
        check(rpAdvertise1a5, 1'h1, "early restore");
        cyc(40);
        check(rpAdvertise1a5, 1'h0, "restore");
        overTemp = 1'h1;
        cyc(5);
        check(port_fault_flag_n_oe_n, 1'h0, "hot fault");
        overTemp = 1'h0;
        cyc(30);
        check(port_fault_flag_n_oe_n, 1'h1, "hot clear");
        overCurrent = 1'h1;
        cyc(15);
        overCurrent = 1'h0;
        cyc(5);
        check(port_fault_flag_n_oe_n, 1'h1, "glitch");
        overCurrent = 1'h1;
        cyc(35);
        check(port_fault_flag_n_oe_n, 1'h0, "oc fault");
        check(hiccupActive, 1'h1, "hiccup");
        check(portSwitchOn, 1'h0, "hiccup off");
        cyc(45);
        check(portSwitchOn, 1'h1, "hiccup on");
        overCurrent = 1'h0;
        cyc(100);
        check(port_fault_flag_n_oe_n, 1'h1, "oc clear");
        check(hiccupActive, 1'h0, "hiccup end");
        portEnable = 1'h0;
        cyc(6);
        check(portSwitchOn, 1'h0, "disable");
        check(fastDischarge, 1'h1, "discharge");
        cyc(30);
        check(fastDischarge, 1'h0, "discharge end");
        portEnable = 1'h1;
        cyc(30);
        softStartDone = 1'h1;
        shortOut = 1'h1;
        cyc(30);
        check(hiccupActive, 1'h0, "low early");
        cyc(500);
        check(hiccupActive, 1'h1, "low hiccup");
        {softStartDone, shortOut, chipEnable} = 3'h0;
        cyc(6);
        check(hiccupActive, 1'h0, "disable clear");
        legacyRes = 1'h1;
        chipEnable = 1'h1;
        cyc(420);
        check(typeALimit, 1'h1, "latch");
        check(portSwitchOn, 1'h1, "A vbus");
        term1 = 2'h2;
        term2 = 2'h2;
        cyc(12);
        check(portSwitchOn, 1'h1, "A no detach");
        legacyRes = 1'h0;
        input_undervoltage_lockout = 1'h1;
        cyc(6);
        check(typeALimit, 1'h0, "lockout");
        input_undervoltage_lockout = 1'h0;
        cyc(420);
        check(typeALimit, 1'h0, "cap no latch");
        end_of_test();
    end
endmodule : testbench
